// ===== hw/amd_decoder.v
`timescale 1ns/10ps
`default_nettype none
`include "amd_map.vh"
module amd_decoder (
	input  wire        CLK,
	input  wire        ARST_N,
	input  wire        START,
	input  wire [15:0] PC,
	input  wire [7:0]  X,
	input  wire [7:0]  Y,
	output reg  [15:0] MEM_ADDR,
	output wire        MEM_RD,
	input  wire [7:0]  MEM_DATA,
	input  wire        MEM_VALID,
	output reg  [4:0]  MODE,
	output reg  [2:0]  GROUP,
	output reg  [7:0]  OPCODE,
	output reg  [7:0]  LITERAL,
	output reg  [15:0] EA,
	output reg  [15:0] NEW_PC,
	output reg  [2:0]  LENGTH,
	output reg         BUSY,
	output reg         DONE,
	output reg         ILLEGAL
);
	// ----------------------------------------
	// states
	// ----------------------------------------
	localparam S_IDLE = 4'h0;
	localparam S_OPC  = 4'h1;
	localparam S_MODE = 4'h2;
	localparam S_B1   = 4'h3;
	localparam S_B2   = 4'h4;
	localparam S_PH   = 4'h5;
	localparam S_PL   = 4'h6;
	localparam S_ADD  = 4'h7;
	localparam S_SUM  = 4'h8;
	localparam S_FIN  = 4'h9;

	reg  [3:0]  st_r;
	reg  [3:0]  st_nxt;
	reg  [15:0] pc_r;
	reg  [7:0]  pre_r;
	reg  [7:0]  b1_r;
	reg  [7:0]  b2_r;
	reg  [7:0]  ph_r;
	reg  [7:0]  pl_r;
	reg  [2:0]  len_r;
	reg         ind;
	reg         use_y;
	wire [4:0]  rom_mode;
	wire        rom_rmw;
	wire [15:0] sum;
	reg  [15:0] base;
	reg         use_idx;

	// ----------------------------------------
	// decode helpers
	// ----------------------------------------
	function is_prefix;
		input [7:0] b;
		begin
			is_prefix = (b == `AMD_PRE_Y) || (b == `AMD_PRE_IND) || (b == `AMD_PRE_IND_Y);
		end
	endfunction

	function [2:0] group_of;
		input [4:0] m;
		begin
			case (m)
				`AMD_M_INH:                             group_of = `AMD_G_INH;
				`AMD_M_IMM:                             group_of = `AMD_G_IMM;
				`AMD_M_DIR_S, `AMD_M_DIR_L:             group_of = `AMD_G_DIR;
				`AMD_M_IDX_0, `AMD_M_IDX_S, `AMD_M_IDX_L: group_of = `AMD_G_IDX;
				`AMD_M_REL_D, `AMD_M_REL_I:             group_of = `AMD_G_REL;
				`AMD_M_BIT_D, `AMD_M_BIT_I, `AMD_M_BTR_D, `AMD_M_BTR_I:
					group_of = `AMD_G_BIT;
				default:                                group_of = `AMD_G_IND;
			endcase
		end
	endfunction

	// operand bytes following the opcode for each mode
	function [1:0] nbytes;
		input [4:0] m;
		begin
			case (m)
				`AMD_M_INH, `AMD_M_IDX_0:       nbytes = 2'd0;
				`AMD_M_DIR_L, `AMD_M_IDX_L,
				`AMD_M_BTR_D, `AMD_M_BTR_I:    nbytes = 2'd2;
				`AMD_M_BAD:                     nbytes = 2'd0;
				default:                        nbytes = 2'd1;
			endcase
		end
	endfunction

	// long forms: full 64 Kbyte reach through two address bytes or a word pointer
	function is_long;
		input [4:0] m;
		begin
			case (m)
				`AMD_M_DIR_L, `AMD_M_IDX_L,
				`AMD_M_IND_L, `AMD_M_IIX_L: is_long = 1'b1;
				default:                    is_long = 1'b0;
			endcase
		end
	endfunction

	// signed offset added to the address just past the instruction
	function [15:0] rel_target;
		input [15:0] base_pc;
		input [7:0]  off;
		begin
			rel_target = base_pc + {{8{off[7]}}, off};
		end
	endfunction

	// ----------------------------------------
	// submodules
	// ----------------------------------------
	// the lookup latches the byte taken in the fetch state, so the mode is ready in S_MODE
	amd_mode_rom u_rom (
		.CLK    (CLK),
		.ARST_N (ARST_N),
		.hi     (MEM_DATA[7:4]),
		.ind    (ind),
		.mode_r (rom_mode),
		.rmw_r  (rom_rmw)
	);

	amd_ea_add u_add (
		.CLK       (CLK),
		.ARST_N    (ARST_N),
		.go        (st_r == S_ADD),
		.base      (base),
		.index     (use_y ? Y : X),
		.use_index (use_idx),
		.sum_r     (sum)
	);

	// ----------------------------------------
	// prefix decode
	// ----------------------------------------
	always @* begin
		ind   = (pre_r == `AMD_PRE_IND) || (pre_r == `AMD_PRE_IND_Y);
		use_y = (pre_r == `AMD_PRE_Y) || (pre_r == `AMD_PRE_IND_Y);
	end

	// ----------------------------------------
	// base and index select
	// ----------------------------------------
	always @* begin
		base    = 16'h0000;
		use_idx = 1'b0;
		case (MODE)
			`AMD_M_DIR_S, `AMD_M_BIT_D, `AMD_M_BTR_D:
				base = {8'h00, b1_r};
			`AMD_M_DIR_L:
				base = {b1_r, b2_r};
			`AMD_M_IDX_0:
				use_idx = 1'b1;
			`AMD_M_IDX_S: begin
				base    = {8'h00, b1_r};
				use_idx = 1'b1;
			end
			`AMD_M_IDX_L: begin
				base    = {b1_r, b2_r};
				use_idx = 1'b1;
			end
			`AMD_M_IND_S, `AMD_M_BIT_I, `AMD_M_BTR_I:
				base = {8'h00, pl_r};
			`AMD_M_IND_L:
				base = {ph_r, pl_r};
			`AMD_M_IIX_S: begin
				base    = {8'h00, pl_r};
				use_idx = 1'b1;
			end
			`AMD_M_IIX_L: begin
				base    = {ph_r, pl_r};
				use_idx = 1'b1;
			end
			default: base = 16'h0000;
		endcase
	end

	// ----------------------------------------
	// mode flags
	// ----------------------------------------
	wire wide_ptr = (MODE == `AMD_M_IND_L) || (MODE == `AMD_M_IIX_L);
	wire is_ind   = (MODE == `AMD_M_IND_S) || (MODE == `AMD_M_IND_L) ||
	                (MODE == `AMD_M_IIX_S) || (MODE == `AMD_M_IIX_L) ||
	                (MODE == `AMD_M_REL_I) || (MODE == `AMD_M_BIT_I) ||
	                (MODE == `AMD_M_BTR_I);
	wire rel      = (MODE == `AMD_M_REL_D) || (MODE == `AMD_M_REL_I) ||
	                (MODE == `AMD_M_BTR_D) || (MODE == `AMD_M_BTR_I);
	// relative offset: last instruction byte, or the byte read through the pointer
	wire [7:0] rel_off = (MODE == `AMD_M_REL_I) ? pl_r :
	                     (MODE == `AMD_M_REL_D) ? b1_r : b2_r;
	wire [15:0] next_pc = pc_r + {13'h0000, len_r};
	// modes with two operand bytes: long direct, long indexed and bit-relative
	wire need_b2  = nbytes(MODE) == 2'd2;

	assign MEM_RD = (st_r == S_OPC) || (st_r == S_B1) || (st_r == S_B2) ||
	                (st_r == S_PH) || (st_r == S_PL);

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	always @* begin
		st_nxt = st_r;
		case (st_r)
			S_IDLE: if (START) st_nxt = S_OPC;
			S_OPC: if (MEM_VALID && !is_prefix(MEM_DATA)) st_nxt = S_MODE;
			S_MODE: begin
				if (rom_mode == `AMD_M_BAD)
					st_nxt = S_FIN;
				else if (nbytes(rom_mode) == 2'd0)
					st_nxt = S_ADD;
				else
					st_nxt = S_B1;
			end
			S_B1: if (MEM_VALID) st_nxt = need_b2 ? S_B2 : (is_ind ? (wide_ptr ? S_PH : S_PL) : S_ADD);
			S_B2: if (MEM_VALID) st_nxt = is_ind ? S_PL : S_ADD;
			S_PH: if (MEM_VALID) st_nxt = S_PL;
			S_PL: if (MEM_VALID) st_nxt = S_ADD;
			S_ADD: st_nxt = S_SUM;
			S_SUM: st_nxt = S_FIN;
			S_FIN: st_nxt = S_IDLE;
			default: st_nxt = S_IDLE;
		endcase
	end

	// ----------------------------------------
	// datapath registers
	// ----------------------------------------
	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			st_r     <= S_IDLE;
			pc_r     <= 16'h0000;
			pre_r    <= 8'h00;
			b1_r     <= 8'h00;
			b2_r     <= 8'h00;
			ph_r     <= 8'h00;
			pl_r     <= 8'h00;
			len_r    <= 3'd0;
			MEM_ADDR <= 16'h0000;
			MODE     <= `AMD_M_INH;
			GROUP    <= `AMD_G_INH;
			OPCODE   <= 8'h00;
			LITERAL  <= 8'h00;
			EA       <= 16'h0000;
			NEW_PC   <= 16'h0000;
			LENGTH   <= 3'd0;
			BUSY     <= 1'b0;
			DONE     <= 1'b0;
			ILLEGAL  <= 1'b0;
		end else begin
			st_r <= st_nxt;
			DONE <= 1'b0;
			case (st_r)
				S_IDLE: if (START) begin
					pc_r     <= PC;
					MEM_ADDR <= PC;
					pre_r    <= 8'h00;
					ph_r     <= 8'h00;
					len_r    <= 3'd1;
					BUSY     <= 1'b1;
					ILLEGAL  <= 1'b0;
				end
				S_OPC: if (MEM_VALID) begin
					if (is_prefix(MEM_DATA))
						pre_r <= MEM_DATA;
					else
						OPCODE <= MEM_DATA;
					MEM_ADDR <= MEM_ADDR + 16'h0001;
					if (is_prefix(MEM_DATA))
						len_r <= len_r + 3'd1;
				end
				S_MODE: begin
					MODE  <= rom_mode;
					GROUP <= group_of(rom_mode);
					len_r <= len_r + {1'b0, nbytes(rom_mode)};
					// prefix 90 has no indirect meaning; 91 needs an indexed target
					// a read-modify-write opcode must never end on a long form
					if (rom_mode == `AMD_M_BAD ||
					    (rom_rmw && is_long(rom_mode)) ||
					    (pre_r == `AMD_PRE_IND_Y && rom_mode != `AMD_M_IIX_S &&
					     rom_mode != `AMD_M_IIX_L))
						ILLEGAL <= 1'b1;
				end
				S_B1: if (MEM_VALID) begin
					b1_r     <= MEM_DATA;
					LITERAL  <= MEM_DATA;
					MEM_ADDR <= need_b2 ? MEM_ADDR + 16'h0001 : {8'h00, MEM_DATA};
				end
				S_B2: if (MEM_VALID) begin
					b2_r     <= MEM_DATA;
					MEM_ADDR <= {8'h00, b1_r}; // bit-relative indirect pointer
				end
				S_PH: if (MEM_VALID) begin
					ph_r     <= MEM_DATA;
					MEM_ADDR <= MEM_ADDR + 16'h0001;
				end
				S_PL: if (MEM_VALID)
					pl_r <= MEM_DATA;
				S_SUM: begin
					EA <= sum;
					NEW_PC <= rel ? rel_target(next_pc, rel_off) : next_pc;
					LENGTH <= len_r;
				end
				S_FIN: begin
					BUSY <= 1'b0;
					DONE <= 1'b1;
				end
				default: BUSY <= BUSY;
			endcase
		end
	end
endmodule // amd_decoder
`default_nettype wire

// ===== hw/amd_ea_add.v
`timescale 1ns/10ps
`default_nettype none
// unsigned index plus base, registered
module amd_ea_add (
	input  wire        CLK,
	input  wire        ARST_N,
	input  wire        go,
	input  wire [15:0] base,
	input  wire [7:0]  index,
	input  wire        use_index,
	output reg  [15:0] sum_r
);
	wire [15:0] idx16 = use_index ? {8'h00, index} : 16'h0000;
	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N)
			sum_r <= 16'h0000;
		else if (go)
			sum_r <= base + idx16;
	end
endmodule // amd_ea_add
`default_nettype wire

// ===== hw/amd_map.vh
`ifndef AMD_MAP_VH
`define AMD_MAP_VH
// ----------------------------------------
// prefix bytes
// ----------------------------------------
`define AMD_PRE_Y         8'h90
`define AMD_PRE_IND       8'h92
`define AMD_PRE_IND_Y     8'h91
// ----------------------------------------
// addressing modes (17)
// ----------------------------------------
`define AMD_M_INH         5'h00
`define AMD_M_IMM         5'h01
`define AMD_M_DIR_S       5'h02
`define AMD_M_DIR_L       5'h03
`define AMD_M_IDX_0       5'h04
`define AMD_M_IDX_S       5'h05
`define AMD_M_IDX_L       5'h06
`define AMD_M_IND_S       5'h07
`define AMD_M_IND_L       5'h08
`define AMD_M_IIX_S       5'h09
`define AMD_M_IIX_L       5'h0a
`define AMD_M_REL_D       5'h0b
`define AMD_M_REL_I       5'h0c
`define AMD_M_BIT_D       5'h0d
`define AMD_M_BIT_I       5'h0e
`define AMD_M_BTR_D       5'h0f
`define AMD_M_BTR_I       5'h10
`define AMD_M_BAD         5'h1f
// ----------------------------------------
// groups (7)
// ----------------------------------------
`define AMD_G_INH         3'h0
`define AMD_G_IMM         3'h1
`define AMD_G_DIR         3'h2
`define AMD_G_IDX         3'h3
`define AMD_G_IND         3'h4
`define AMD_G_REL         3'h5
`define AMD_G_BIT         3'h6
// ----------------------------------------
// opcode high nibble groups
// ----------------------------------------
`define AMD_HI_BIT        4'h0
`define AMD_HI_BITR       4'h1
`define AMD_HI_REL        4'h2
`define AMD_HI_RMW_S      4'h3
`define AMD_HI_RMW_A      4'h4
`define AMD_HI_RMW_X      4'h5
`define AMD_HI_RMW_XS     4'h6
`define AMD_HI_RMW_X0     4'h7
`define AMD_HI_INH        4'h8
`define AMD_HI_INH2       4'h9
`define AMD_HI_IMM        4'ha
`define AMD_HI_DS         4'hb
`define AMD_HI_DL         4'hc
`define AMD_HI_XL         4'hd
`define AMD_HI_XS         4'he
`define AMD_HI_X0         4'hf
`define AMD_PAGE0_MAX     16'h00ff
`endif

// ===== hw/amd_mode_rom.v
`timescale 1ns/10ps
`default_nettype none
`include "amd_map.vh"
// opcode class -> base mode, registered lookup
module amd_mode_rom (
	input  wire       CLK,
	input  wire       ARST_N,
	input  wire [3:0] hi,
	input  wire       ind,
	output reg  [4:0] mode_r,
	output reg        rmw_r
);
	reg [4:0] mode_nxt;
	reg       rmw_nxt;
	always @* begin
		rmw_nxt = 1'b0;
		case (hi)
			`AMD_HI_BIT: begin
				mode_nxt = ind ? `AMD_M_BIT_I : `AMD_M_BIT_D;
				rmw_nxt  = 1'b1;
			end
			`AMD_HI_BITR: begin
				mode_nxt = ind ? `AMD_M_BTR_I : `AMD_M_BTR_D;
				rmw_nxt  = 1'b1;
			end
			`AMD_HI_REL:   mode_nxt = ind ? `AMD_M_REL_I : `AMD_M_REL_D;
			`AMD_HI_RMW_S: begin
				mode_nxt = ind ? `AMD_M_IND_S : `AMD_M_DIR_S;
				rmw_nxt  = 1'b1;
			end
			`AMD_HI_RMW_A, `AMD_HI_RMW_X, `AMD_HI_INH, `AMD_HI_INH2:
				mode_nxt = ind ? `AMD_M_BAD : `AMD_M_INH;
			`AMD_HI_RMW_XS: begin
				mode_nxt = ind ? `AMD_M_IIX_S : `AMD_M_IDX_S;
				rmw_nxt  = 1'b1;
			end
			`AMD_HI_RMW_X0: begin
				mode_nxt = ind ? `AMD_M_BAD : `AMD_M_IDX_0;
				rmw_nxt  = 1'b1;
			end
			`AMD_HI_IMM:   mode_nxt = ind ? `AMD_M_BAD : `AMD_M_IMM;
			`AMD_HI_DS:    mode_nxt = ind ? `AMD_M_IND_S : `AMD_M_DIR_S;
			`AMD_HI_DL:    mode_nxt = ind ? `AMD_M_IND_L : `AMD_M_DIR_L;
			`AMD_HI_XL:    mode_nxt = ind ? `AMD_M_IIX_L : `AMD_M_IDX_L;
			`AMD_HI_XS:    mode_nxt = ind ? `AMD_M_IIX_S : `AMD_M_IDX_S;
			`AMD_HI_X0:    mode_nxt = ind ? `AMD_M_BAD : `AMD_M_IDX_0;
			default:       mode_nxt = `AMD_M_BAD;
		endcase
	end
	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			mode_r <= `AMD_M_INH;
			rmw_r  <= 1'b0;
		end else begin
			mode_r <= mode_nxt;
			rmw_r  <= rmw_nxt;
		end
	end
endmodule // amd_mode_rom
`default_nettype wire

// ===== sim/amd_decoder_props.sv
`timescale 1ns/10ps
`default_nettype none
`include "amd_map.vh"
module amd_decoder_props (
	input wire logic        CLK,
	input wire logic        ARST_N,
	input wire logic        START,
	input wire logic [15:0] PC,
	input wire logic [7:0]  X,
	input wire logic        MEM_RD,
	input wire logic        MEM_VALID,
	input wire logic [4:0]  MODE,
	input wire logic [2:0]  GROUP,
	input wire logic [7:0]  LITERAL,
	input wire logic [15:0] EA,
	input wire logic [15:0] NEW_PC,
	input wire logic [2:0]  LENGTH,
	input wire logic        BUSY,
	input wire logic        DONE,
	input wire logic        ILLEGAL
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!ARST_N);
	// ----------------
	// handshake
	// ----------------
	a_done_pulse: assert property (DONE |=> !DONE) else $error("done held too long");
	a_start_taken: assert property (START && !BUSY && !DONE |=> BUSY) else $error("start lost");
	a_done_bound: assert property ($rose(BUSY) |-> ##[3:60] DONE) else $error("decode hung");
	a_idle_hold: assert property (!BUSY && !START && !DONE |=> $stable(EA) && $stable(MODE)
		&& $stable(NEW_PC)) else $error("outputs moved while idle");
	// ----------------
	// address results
	// ----------------
	a_inh_length: assert property (
		DONE && MODE == `AMD_M_INH && !ILLEGAL |-> LENGTH inside {3'h1, 3'h2})
		else $error("inherent length wrong");
	a_next_pc: assert property (
		DONE && !ILLEGAL && GROUP < `AMD_G_REL |-> NEW_PC == PC + {13'h0, LENGTH})
		else $error("next pc wrong");
	a_page0_short: assert property (
		DONE && MODE inside {`AMD_M_DIR_S, `AMD_M_IDX_0, `AMD_M_IND_S} |-> EA[15:8] == 8'h00)
		else $error("short mode left page zero");
	a_short_reach: assert property (
		DONE && MODE inside {`AMD_M_IDX_S, `AMD_M_IIX_S} |-> EA <= 16'h01fe)
		else $error("short index reach exceeded");
	a_idx0_ea: assert property (
		DONE && MODE == `AMD_M_IDX_0 && LENGTH == 3'h1 |-> EA == {8'h00, X})
		else $error("no-offset index address wrong");
	a_rel_pc: assert property (
		DONE && MODE == `AMD_M_REL_D |-> NEW_PC == PC + {13'h0, LENGTH}
		+ {{8{LITERAL[7]}}, LITERAL}) else $error("relative target wrong");
	a_group_idx: assert property (
		DONE && MODE inside {`AMD_M_IDX_0, `AMD_M_IDX_S, `AMD_M_IDX_L} |-> GROUP == `AMD_G_IDX)
		else $error("indexed group wrong");
	c_iix: cover property (DONE && MODE == `AMD_M_IIX_S);
	c_rel: cover property (DONE && GROUP == `AMD_G_REL);
	c_wait: cover property (MEM_RD && !MEM_VALID);
endmodule // amd_decoder_props
bind amd_decoder amd_decoder_props u_amd_decoder_props (.CLK(CLK), .ARST_N(ARST_N),
	.START(START), .PC(PC), .X(X), .MEM_RD(MEM_RD), .MEM_VALID(MEM_VALID), .MODE(MODE),
	.GROUP(GROUP), .LITERAL(LITERAL), .EA(EA), .NEW_PC(NEW_PC), .LENGTH(LENGTH),
	.BUSY(BUSY), .DONE(DONE), .ILLEGAL(ILLEGAL));
`default_nettype wire

// ===== sim/amd_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
module amd_mem_model (
	input  wire logic        CLK,
	input  wire logic        slow,
	input  wire logic [15:0] MEM_ADDR,
	input  wire logic        MEM_RD,
	output var  logic [7:0]  MEM_DATA,
	output var  logic        MEM_VALID
);
	logic [7:0] mem [0:65535];
	logic       ph_r = 1'b0;
	always @(posedge CLK) ph_r <= slow ? ~ph_r : 1'b1;
	// no pull on the data lines: outside a valid read show a wrong byte, not the right one
	always_comb begin
		MEM_VALID = MEM_RD && ph_r;
		MEM_DATA = MEM_VALID ? mem[MEM_ADDR] : ~mem[MEM_ADDR];
	end
endmodule // amd_mem_model
`default_nettype wire

// ===== sim/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "amd_map.vh"
module tb_top;
	logic        CLK, ARST_N, START, slow, MEM_RD, MEM_VALID, BUSY, DONE, ILLEGAL;
	logic [15:0] PC, MEM_ADDR, EA, NEW_PC;
	logic [7:0]  X, Y, MEM_DATA, OPCODE, LITERAL;
	logic [4:0]  MODE;
	logic [2:0]  GROUP, LENGTH;
	int          num_errors = 0;
	int          checked = 0;
	amd_decoder u_amd_decoder (.CLK(CLK), .ARST_N(ARST_N), .START(START), .PC(PC), .X(X),
		.Y(Y), .MEM_ADDR(MEM_ADDR), .MEM_RD(MEM_RD), .MEM_DATA(MEM_DATA),
		.MEM_VALID(MEM_VALID), .MODE(MODE), .GROUP(GROUP), .OPCODE(OPCODE),
		.LITERAL(LITERAL), .EA(EA), .NEW_PC(NEW_PC), .LENGTH(LENGTH), .BUSY(BUSY),
		.DONE(DONE), .ILLEGAL(ILLEGAL));
	amd_mem_model u_amd_mem_model (.CLK(CLK), .slow(slow), .MEM_ADDR(MEM_ADDR),
		.MEM_RD(MEM_RD), .MEM_DATA(MEM_DATA), .MEM_VALID(MEM_VALID));
	initial begin
		CLK = 1'b0;
		forever #5 CLK = ~CLK;
	end
	// ----------------
	// helpers
	// ----------------
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic put(input logic [15:0] a, input logic [7:0] b0, b1, b2);
		u_amd_mem_model.mem[a] = b0;
		u_amd_mem_model.mem[a + 16'h1] = b1;
		u_amd_mem_model.mem[a + 16'h2] = b2;
	endtask
	// start is dropped once taken; done is judged in the cycle it shows
	task automatic run(input logic [15:0] pc);
		int n;
		n = 0;
		@(posedge CLK); #1;
		PC = pc;
		START = 1'b1;
		@(posedge CLK); #1;
		START = 1'b0;
		while (DONE !== 1'b1 && n < 100) begin
			@(posedge CLK); #1;
			n++;
		end
		chk(16'(n < 100), 16'h1);
	endtask
	task automatic want(input logic [4:0] m, input logic [2:0] len);
		chk({11'h0, MODE}, {11'h0, m});
		chk({13'h0, LENGTH}, {13'h0, len});
		chk({15'h0, BUSY}, 16'h0000);
		chk({15'h0, MEM_RD}, 16'h0000);
		chk({15'h0, ILLEGAL}, 16'h0000);
		if (m != `AMD_M_REL_D && m != `AMD_M_REL_I &&
		    m != `AMD_M_BTR_D && m != `AMD_M_BTR_I)
			chk(NEW_PC, PC + {13'h0, len});
	endtask
	// ----------------
	// scenarios
	// ----------------
	task automatic t_plain;
		put(16'h0100, 8'h80, 8'h00, 8'h00);
		run(16'h0100);
		want(`AMD_M_INH, 3'h1);
		chk({13'h0, GROUP}, {13'h0, `AMD_G_INH});
		chk({8'h0, OPCODE}, 16'h0080);
		put(16'h0200, 8'ha0, 8'h55, 8'h00);
		run(16'h0200);
		want(`AMD_M_IMM, 3'h2);
		chk({8'h0, LITERAL}, 16'h0055);
		$display("test plain done");
	endtask
	task automatic t_direct;
		put(16'h0300, 8'hb0, 8'h34, 8'h00);
		run(16'h0300);
		want(`AMD_M_DIR_S, 3'h2);
		chk(EA, 16'h0034);
		put(16'h0310, 8'hc0, 8'h12, 8'h34);
		run(16'h0310);
		want(`AMD_M_DIR_L, 3'h3);
		chk(EA, 16'h1234);
		$display("test direct done");
	endtask
	task automatic t_indexed;
		X = 8'hff;
		put(16'h0400, 8'hf0, 8'h00, 8'h00);
		run(16'h0400);
		want(`AMD_M_IDX_0, 3'h1);
		chk(EA, 16'h00ff);
		put(16'h0410, 8'he0, 8'hff, 8'h00);
		run(16'h0410);
		want(`AMD_M_IDX_S, 3'h2);
		chk(EA, 16'h01fe);
		put(16'h0420, 8'hd0, 8'h12, 8'h00);
		run(16'h0420);
		want(`AMD_M_IDX_L, 3'h3);
		chk(EA, 16'h12ff);
		X = 8'h01;
		Y = 8'h20;
		put(16'h0500, 8'h90, 8'he0, 8'h10);
		run(16'h0500);
		want(`AMD_M_IDX_S, 3'h3);
		chk(EA, 16'h0030);
		$display("test indexed done");
	endtask
	task automatic t_indirect;
		put(16'h0040, 8'h77, 8'h00, 8'h00);
		put(16'h0050, 8'hab, 8'hcd, 8'h00);
		put(16'h0060, 8'hff, 8'h00, 8'h00);
		put(16'h0600, 8'h92, 8'hb0, 8'h40);
		run(16'h0600);
		want(`AMD_M_IND_S, 3'h3);
		chk(EA, 16'h0077);
		chk(MEM_ADDR, 16'h0040);
		put(16'h0610, 8'h92, 8'hc0, 8'h50);
		run(16'h0610);
		want(`AMD_M_IND_L, 3'h3);
		chk(EA, 16'habcd);
		X = 8'hff;
		put(16'h0620, 8'h92, 8'he0, 8'h60);
		run(16'h0620);
		want(`AMD_M_IIX_S, 3'h3);
		chk(EA, 16'h01fe);
		Y = 8'h10;
		put(16'h0630, 8'h91, 8'he0, 8'h60);
		run(16'h0630);
		want(`AMD_M_IIX_S, 3'h3);
		chk(EA, 16'h010f);
		$display("test indirect done");
	endtask
	task automatic t_relative;
		put(16'h0700, 8'h20, 8'hfe, 8'h00);
		run(16'h0700);
		want(`AMD_M_REL_D, 3'h2);
		chk(NEW_PC, 16'h0700);
		slow = 1'b1;
		put(16'h0710, 8'h20, 8'h7f, 8'h00);
		run(16'h0710);
		chk(NEW_PC, 16'h0791);
		slow = 1'b0;
		$display("test relative done");
	endtask
	task automatic t_bits;
		put(16'h0800, 8'h00, 8'h34, 8'h00);
		run(16'h0800);
		want(`AMD_M_BIT_D, 3'h2);
		chk({13'h0, GROUP}, {13'h0, `AMD_G_BIT});
		chk(EA, 16'h0034);
		put(16'h0810, 8'h10, 8'h34, 8'h05);
		run(16'h0810);
		want(`AMD_M_BTR_D, 3'h3);
		chk(NEW_PC, 16'h0818);
		put(16'h0820, 8'h92, 8'h10, 8'h40);
		u_amd_mem_model.mem[16'h0823] = 8'h02;
		run(16'h0820);
		want(`AMD_M_BTR_I, 3'h4);
		chk(EA, 16'h0077);
		chk(NEW_PC, 16'h0826);
		put(16'h0830, 8'h92, 8'h20, 8'h50);
		run(16'h0830);
		want(`AMD_M_REL_I, 3'h3);
		chk(NEW_PC, 16'h07de);
		X = 8'h10;
		put(16'h0840, 8'h92, 8'hd0, 8'h50);
		run(16'h0840);
		want(`AMD_M_IIX_L, 3'h3);
		chk(EA, 16'habdd);
		put(16'h0850, 8'h92, 8'ha0, 8'h00);
		run(16'h0850);
		chk({11'h0, MODE}, {11'h0, `AMD_M_BAD});
		chk({15'h0, ILLEGAL}, 16'h0001);
		$display("test bits done");
	endtask
	// reset lands while a long indirect decode is in flight
	task automatic t_reset;
		put(16'h0900, 8'h92, 8'hc0, 8'h50);
		@(posedge CLK); #1;
		PC = 16'h0900;
		START = 1'b1;
		@(posedge CLK); #1;
		START = 1'b0;
		repeat (3) @(posedge CLK);
		#1;
		ARST_N = 1'b0;
		#1;
		chk({15'h0, BUSY}, 16'h0000);
		chk({11'h0, MODE}, {11'h0, `AMD_M_INH});
		@(posedge CLK); #1;
		ARST_N = 1'b1;
		run(16'h0100);
		want(`AMD_M_INH, 3'h1);
		$display("test reset done");
	endtask
	task automatic final_report;
		$display("checks=%0d errors=%0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		ARST_N = 1'b0;
		START = 1'b0;
		slow = 1'b0;
		PC = 16'h0000;
		X = 8'h00;
		Y = 8'h00;
		repeat (8) @(posedge CLK);
		#1;
		ARST_N = 1'b1;
		chk({11'h0, MODE}, {11'h0, `AMD_M_INH});
		chk(EA, 16'h0000);
		t_plain;
		t_direct;
		t_indexed;
		t_indirect;
		t_relative;
		t_bits;
		t_reset;
		final_report;
	end
	initial begin
		#20000;
		num_errors++;
		final_report;
	end
endmodule // tb_top
`default_nettype wire
